// ### rtl/virt_capability_report_regs.vh
// register indices, field layouts and fixed capability values of the capability bank
`ifndef VIRT_CAPABILITY_REPORT_REGS_VH
`define VIRT_CAPABILITY_REPORT_REGS_VH
`define IDX_CRF_MUST_BE_ONE      12'h488
`define IDX_CRF_MAY_BE_ONE       12'h489
`define IDX_FIELD_INDEX_LIMIT    12'h48A
`define IDX_NESTED_TABLE_TAG_CAP 12'h48C
`define IDX_VM_FUNCTION_ALLOWED  12'h491
`define CRF_MUST_BE_ONE_VAL      64'h0000_0000_0000_2000
`define CRF_MAY_BE_ONE_VAL       64'h0000_0000_0037_27FF
`define FIELD_INDEX_LIMIT_VAL    9'h017
`define VM_FUNCTION_ALLOWED_VAL  64'h0000_0000_0000_0001
`define CAP_EXEC_ONLY            0
`define CAP_WALK4                6
`define CAP_UC                   8
`define CAP_WB                   14
`define CAP_DIR_2M               16
`define CAP_DIRPTR_1G            17
`define CAP_NFLUSH               20
`define CAP_AD_FLAGS             21
`define CAP_EXT_EXIT             22
`define CAP_NFLUSH_SINGLE        25
`define CAP_NFLUSH_ALL           26
`define CAP_TFLUSH               32
`define CAP_TFLUSH_ADDR          40
`define CAP_TFLUSH_SINGLE        41
`define CAP_TFLUSH_ALL           42
`define CAP_TFLUSH_KEEPG         43
`define CAP_RSVD_MASK            64'hFFFF_F0FE_F98C_BEBE
`define PRI_ACT_SECONDARY        63
`define SEC_NESTED_TABLE         33
`define SEC_CPU_TAG              37
`define SEC_VM_FUNCTION          45
`define FC_RSVD_HI               31:15
`define FC_RSVD_12               12
`define FC_WIDTH                 14:13
`define FC_TYPE                  11:10
`define FC_INDEX                 9:1
`define FC_ACCESS                0
`define WIDTH_16                 2'h0
`define TYPE_CONTROL             2'h0
`define TYPE_GUEST               2'h2
`define TYPE_HOST                2'h3
`define FC_CPU_TAG               32'h0000_0000
`define FC_NOTIFY_VEC            32'h0000_0002
`define FC_TABLE_PTR_IDX         32'h0000_0004
`endif

// ### rtl/virt_capability_report.v
// read-only virtualization capability bank with control-register-4 masking and field code decode
`timescale 1ns/10ps
`include "virt_capability_report_regs.vh"
// Behaviour
// R01 - must-be-one mask forces control bits high
// R02 - may-be-one zero bits hold control bits low
// R03 - must-be-one bits are subset of may-be-one
// R04 - field code splits width type index access
// R05 - index limit in bits 9:1, rest zero
// R06 - bit 0 reports execute-only translations
// R07 - bit 6 reports four-level walk
// R08 - bits 8 and 14 report uc, wb
// R09 - bits 16, 17 report large page mapping
// R10 - bits 20, 25, 26 report table flush
// R11 - bit 21 reports accessed dirty flags
// R12 - extended violation info only when bit 22
// R13 - bits 32, 40-43 report tag flush
// R14 - unassigned capability bits read zero
// R15 - capability register needs secondary plus table/tag
// R16 - entry fails on disallowed vm-function bit
// R17 - vm-function register exists with bits 63, 45
// R18 - width zero means 16-bit, even code
// R19 - type zero control, index distinguishes fields
// R20 - tag 0, vector 2, table index 4
// R21 - 16-bit controls need their enabling control
// R22 - type 2 guest, type 3 host
// R23 - registers are constants, writes ignored
module virt_capability_report (
	input  wire        clk_sys,
	input  wire        rst,
	input  wire        rd_en,
	input  wire        wr_en,
	input  wire [11:0] reg_index,
	input  wire [63:0] wr_data,
	input  wire [63:0] primary_exec_capability,
	input  wire [63:0] secondary_exec_capability,
	input  wire        feat_exec_only,
	input  wire        feat_walk4,
	input  wire        feat_uc,
	input  wire        feat_wb,
	input  wire        feat_dir_2m,
	input  wire        feat_dirptr_1g,
	input  wire        feat_nflush,
	input  wire        feat_nflush_single,
	input  wire        feat_nflush_all,
	input  wire        feat_ad_flags,
	input  wire        feat_ext_exit,
	input  wire        feat_tflush,
	input  wire [3:0]  feat_tflush_types,
	input  wire        feat_posted_intr,
	input  wire        feat_virt_exception,
	input  wire        virt_active,
	input  wire [63:0] control_register_four_req,
	input  wire        entry_check,
	input  wire [63:0] vm_function_ctl,
	input  wire        ctl_act_secondary,
	input  wire        ctl_vm_function,
	input  wire        violation_event,
	input  wire [31:0] field_code,
	output reg  [63:0] rd_data,
	output reg         rd_valid,
	output reg         rd_fault,
	output reg  [63:0] control_register_four_eff,
	output reg         entry_fail,
	output reg         ext_exit_info,
	output reg  [1:0]  fc_width,
	output reg  [1:0]  fc_type,
	output reg  [8:0]  fc_index,
	output reg         fc_access,
	output reg         fc_valid,
	output reg         fc_is_guest,
	output reg         fc_is_host,
	output reg         fc_supported
);

	reg  [63:0] cap_raw;
	wire [63:0] cap_val;
	wire        cap_present;
	wire        vmf_present;
	reg  [63:0] rd_nxt;
	reg         hit_nxt;
	wire        fc_ok;
	reg         fc_sup_nxt;

	// capability word built from feature straps
	always @* begin
		cap_raw                        = 64'h0000_0000_0000_0000;
		cap_raw[`CAP_EXEC_ONLY]        = feat_exec_only;      // [R06]
		cap_raw[`CAP_WALK4]            = feat_walk4;          // [R07]
		cap_raw[`CAP_UC]               = feat_uc;             // [R08]
		cap_raw[`CAP_WB]               = feat_wb;             // [R08]
		cap_raw[`CAP_DIR_2M]           = feat_dir_2m;         // [R09]
		cap_raw[`CAP_DIRPTR_1G]        = feat_dirptr_1g;      // [R09]
		cap_raw[`CAP_NFLUSH]           = feat_nflush;         // [R10]
		cap_raw[`CAP_NFLUSH_SINGLE]    = feat_nflush_single;  // [R10]
		cap_raw[`CAP_NFLUSH_ALL]       = feat_nflush_all;     // [R10]
		cap_raw[`CAP_AD_FLAGS]         = feat_ad_flags;       // [R11]
		cap_raw[`CAP_EXT_EXIT]         = feat_ext_exit;       // [R12]
		cap_raw[`CAP_TFLUSH]           = feat_tflush;         // [R13]
		cap_raw[`CAP_TFLUSH_KEEPG:`CAP_TFLUSH_ADDR] = feat_tflush_types; // [R13]
	end

	assign cap_val = cap_raw & ~`CAP_RSVD_MASK; // [R14]

	assign cap_present = primary_exec_capability[`PRI_ACT_SECONDARY] &
		(secondary_exec_capability[`SEC_NESTED_TABLE] | secondary_exec_capability[`SEC_CPU_TAG]); // [R15]
	assign vmf_present = primary_exec_capability[`PRI_ACT_SECONDARY] &
		secondary_exec_capability[`SEC_VM_FUNCTION]; // [R17]

	// read mux; absent registers fault like unmapped indices
	always @* begin
		rd_nxt  = 64'h0000_0000_0000_0000;
		hit_nxt = 1'b1;
		case (reg_index)
			`IDX_CRF_MUST_BE_ONE: rd_nxt = `CRF_MUST_BE_ONE_VAL & `CRF_MAY_BE_ONE_VAL; // [R03]
			`IDX_CRF_MAY_BE_ONE: rd_nxt = `CRF_MAY_BE_ONE_VAL;
			`IDX_FIELD_INDEX_LIMIT: rd_nxt = {54'h0, `FIELD_INDEX_LIMIT_VAL, 1'b0}; // [R05]
			`IDX_NESTED_TABLE_TAG_CAP: begin
				rd_nxt  = cap_present ? cap_val : 64'h0000_0000_0000_0000;
				hit_nxt = cap_present; // [R15]
			end
			`IDX_VM_FUNCTION_ALLOWED: begin
				rd_nxt  = vmf_present ? `VM_FUNCTION_ALLOWED_VAL : 64'h0000_0000_0000_0000;
				hit_nxt = vmf_present; // [R17]
			end
			default: hit_nxt = 1'b0;
		endcase
	end

	// field code decode: reserved bits zero, 16-bit codes even
	assign fc_ok = (field_code[`FC_RSVD_HI] == 17'h00000) & ~field_code[`FC_RSVD_12] &
		~((field_code[`FC_WIDTH] == `WIDTH_16) & field_code[`FC_ACCESS]); // [R04] [R18]

	always @* begin
		case (field_code)
			`FC_CPU_TAG: fc_sup_nxt = secondary_exec_capability[`SEC_CPU_TAG]; // [R20] [R21]
			`FC_NOTIFY_VEC: fc_sup_nxt = feat_posted_intr; // [R20] [R21]
			`FC_TABLE_PTR_IDX: fc_sup_nxt = feat_virt_exception; // [R20] [R21]
			default: fc_sup_nxt = 1'b0;
		endcase
	end

	// writes are ignored on purpose: the bank is fixed silicon, a write only faults
	always @(posedge clk_sys) begin
		if (rst) begin
			rd_data       <= 64'h0000_0000_0000_0000;
			rd_valid      <= 1'b0;
			rd_fault      <= 1'b0;
			control_register_four_eff <= 64'h0000_0000_0000_0000;
			entry_fail    <= 1'b0;
			ext_exit_info <= 1'b0;
			fc_width      <= 2'h0;
			fc_type       <= 2'h0;
			fc_index      <= 9'h000;
			fc_access     <= 1'b0;
			fc_valid      <= 1'b0;
			fc_is_guest   <= 1'b0;
			fc_is_host    <= 1'b0;
			fc_supported  <= 1'b0;
		end else begin
			rd_valid <= rd_en & hit_nxt;
			rd_fault <= (rd_en & ~hit_nxt) | wr_en; // [R23]
			if (rd_en) begin
				rd_data <= rd_nxt;
			end
			if (virt_active) begin
				control_register_four_eff <= (control_register_four_req | `CRF_MUST_BE_ONE_VAL) &
					`CRF_MAY_BE_ONE_VAL; // [R01] [R02]
			end else begin
				control_register_four_eff <= control_register_four_req;
			end
			entry_fail <= entry_check & ctl_act_secondary & ctl_vm_function &
				(|(vm_function_ctl & ~`VM_FUNCTION_ALLOWED_VAL)); // [R16]
			ext_exit_info <= violation_event & cap_val[`CAP_EXT_EXIT]; // [R12]
			fc_width     <= field_code[`FC_WIDTH]; // [R04]
			fc_type      <= field_code[`FC_TYPE];
			fc_index     <= field_code[`FC_INDEX]; // [R19]
			fc_access    <= field_code[`FC_ACCESS];
			fc_valid     <= fc_ok;
			fc_is_guest  <= fc_ok & (field_code[`FC_TYPE] == `TYPE_GUEST); // [R22]
			fc_is_host   <= fc_ok & (field_code[`FC_TYPE] == `TYPE_HOST); // [R22]
			fc_supported <= fc_ok & (field_code[`FC_TYPE] == `TYPE_CONTROL) & fc_sup_nxt; // [R19]
		end
	end

endmodule

// ### testbench/virt_capability_report_props.sv
// concurrent checks on the capability bank ports
`timescale 1ns/10ps
`include "virt_capability_report_regs.vh"
module virt_capability_report_props (
	input logic        clk_sys,
	input logic        rst,
	input logic        rd_en,
	input logic        wr_en,
	input logic [11:0] reg_index,
	input logic [63:0] rd_data,
	input logic        rd_valid,
	input logic        rd_fault,
	input logic        virt_active,
	input logic [63:0] control_register_four_eff,
	input logic [31:0] field_code,
	input logic [1:0]  fc_width,
	input logic [1:0]  fc_type,
	input logic [8:0]  fc_index
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	AST_RD_ONCE: assert property (rd_en && !wr_en |=> rd_valid != rd_fault)
		else $error("read not answered exactly once");
	AST_WR_FAULT: assert property (wr_en |=> rd_fault && !rd_valid)
		else $error("write not refused");
	AST_LIMIT: assert property (rd_en && !wr_en && reg_index == `IDX_FIELD_INDEX_LIMIT |=> rd_valid && rd_data == {54'h0, `FIELD_INDEX_LIMIT_VAL, 1'b0})
		else $error("index limit read wrong");
	AST_CAP_RSVD: assert property (rd_en && reg_index == `IDX_NESTED_TABLE_TAG_CAP |=> (rd_data & `CAP_RSVD_MASK) == 64'h0)
		else $error("unassigned capability bit set");
	AST_CRF_ONE: assert property (virt_active |=> (control_register_four_eff & `CRF_MUST_BE_ONE_VAL) == `CRF_MUST_BE_ONE_VAL)
		else $error("forced-one control bit low");
	AST_CRF_ZERO: assert property (virt_active |=> (control_register_four_eff & ~`CRF_MAY_BE_ONE_VAL) == 64'h0)
		else $error("forced-zero control bit high");
	AST_FC_WT: assert property (1'b1 |=> fc_width == $past(field_code[14:13]) && fc_type == $past(field_code[11:10]))
		else $error("field code width or type wrong");
	AST_FC_IDX: assert property (1'b1 |=> fc_index == $past(field_code[9:1]))
		else $error("field code index wrong");
	cover property (rd_valid);
	cover property (rd_fault);
	cover property (virt_active ##1 control_register_four_eff != 64'h0);
endmodule

// ### testbench/virt_capability_report_test.sv
// self-checking bench for the capability bank
`timescale 1ns/10ps
`include "virt_capability_report_regs.vh"
module virt_capability_report_test;
	logic        clk_sys = 0, rst = 1, rd_en = 0, wr_en = 0, s = 1, virt_active = 0, violation_event = 0;
	logic        entry_check = 0, ctl_act_secondary = 0, ctl_vm_function = 0;
	logic [11:0] reg_index = 0;
	logic [31:0] field_code = 0;
	logic [63:0] wr_data = 0, control_register_four_req = 0, vm_function_ctl = 0;
	logic [63:0] primary_exec_capability = 0, secondary_exec_capability = 0;
	logic [63:0] rd_data, control_register_four_eff;
	logic        rd_valid, rd_fault, entry_fail, ext_exit_info, fc_access, fc_valid, fc_is_guest, fc_is_host, fc_supported;
	logic        feat_exec_only, feat_walk4, feat_uc, feat_wb, feat_dir_2m, feat_dirptr_1g, feat_nflush, feat_nflush_single;
	logic        feat_nflush_all, feat_ad_flags, feat_ext_exit, feat_tflush, feat_posted_intr, feat_virt_exception;
	logic [3:0]  feat_tflush_types;
	logic [1:0]  fc_width, fc_type;
	logic [8:0]  fc_index;
	int          miscompares = 0, cmp_count = 0;
	// all straps follow one bit so a whole-register pattern stays cheap to predict
	assign {feat_exec_only, feat_walk4, feat_uc, feat_wb, feat_dir_2m, feat_dirptr_1g, feat_nflush, feat_nflush_single,
		feat_nflush_all, feat_ad_flags, feat_ext_exit, feat_tflush, feat_tflush_types, feat_posted_intr,
		feat_virt_exception} = {18{s}};
	virt_capability_report i_dut (.*);
	always #25 clk_sys = ~clk_sys;
	task chk(input string n, input logic [63:0] e, input logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task settle;
		@(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	task acc(input logic [11:0] a, input logic [63:0] e, input logic f, input logic w);
		@(posedge clk_sys);
		rd_en <= !w;
		wr_en <= w;
		reg_index <= a;
		@(posedge clk_sys);
		rd_en <= 0;
		wr_en <= 0;
		@(negedge clk_sys);
		chk("rd_fault", f, rd_fault);
		chk("rd_valid", !f, rd_valid);
		if (!w) chk("rd_data", e, rd_data);
	endtask
	task fc(input logic [31:0] c, input logic [17:0] e);
		@(posedge clk_sys);
		field_code <= c;
		settle;
		chk("fc", e, {fc_valid, fc_is_guest, fc_is_host, fc_supported, fc_width, fc_type, fc_index, fc_access});
	endtask
	task wrap_up;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		miscompares++;
		wrap_up;
	end
	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 0;
		primary_exec_capability <= 64'h8000_0000_0000_0000;
		secondary_exec_capability <= 64'h0000_2022_0000_0000;
		acc(12'h488, 64'h2000, 0, 0);
		acc(12'h489, 64'h3727FF, 0, 0);
		acc(12'h48A, 64'h2E, 0, 0);
		acc(12'h48C, 64'h0000_0F01_0673_4141, 0, 0);
		acc(12'h491, 64'h1, 0, 0);
		acc(12'h48B, 64'h0, 1, 0);
		acc(12'h48C, 64'h0, 1, 1);
		acc(12'h48C, 64'h0000_0F01_0673_4141, 0, 0);
		$display("test reads done");
		secondary_exec_capability <= 64'h0000_2000_0000_0000;
		acc(12'h48C, 64'h0, 1, 0);
		secondary_exec_capability <= 64'h0000_0002_0000_0000;
		acc(12'h491, 64'h0, 1, 0);
		primary_exec_capability <= 64'h0;
		secondary_exec_capability <= 64'h0000_2022_0000_0000;
		acc(12'h48C, 64'h0, 1, 0);
		acc(12'h491, 64'h0, 1, 0);
		primary_exec_capability <= 64'h8000_0000_0000_0000;
		$display("test presence done");
		fc(32'h4, 18'h24004);
		fc(32'h2, 18'h24002);
		fc(32'h0, 18'h24000);
		fc(32'h80E, 18'h3080E);
		fc(32'hC0C, 18'h28C0C);
		fc(32'h2001, 18'h21001);
		fc(32'h1, 18'h00001);
		fc(32'h8000, 18'h0);
		fc(32'h1000, 18'h0);
		$display("test field codes done");
		@(posedge clk_sys);
		{entry_check, ctl_act_secondary, ctl_vm_function, violation_event, virt_active} <= 5'h1F;
		vm_function_ctl <= 64'h2;
		control_register_four_req <= '1;
		settle;
		chk("entry_fail", 1, entry_fail);
		chk("ext_exit_info", 1, ext_exit_info);
		chk("control_register_four_eff", `CRF_MAY_BE_ONE_VAL, control_register_four_eff);
		@(posedge clk_sys);
		vm_function_ctl <= 64'h1;
		control_register_four_req <= 64'h0;
		s <= 0;
		settle;
		chk("entry_fail", 0, entry_fail);
		chk("ext_exit_info", 0, ext_exit_info);
		chk("control_register_four_eff", `CRF_MUST_BE_ONE_VAL, control_register_four_eff);
		@(posedge clk_sys);
		vm_function_ctl <= 64'h2;
		ctl_vm_function <= 0;
		virt_active <= 0;
		settle;
		chk("entry_fail", 0, entry_fail);
		chk("control_register_four_eff", 64'h0, control_register_four_eff);
		fc(32'h2, 18'h20002);
		acc(12'h48C, 64'h0, 0, 0);
		$display("test side paths done");
		wrap_up;
	end
endmodule
bind virt_capability_report virt_capability_report_props u_props (.*);
